// file: verilog/mlic_cfg.svh
// Purpose: constants for the multilevel interrupt controller core
// Assumes: 100 MHz clock, classic wishbone register access
// Notes:   offsets are register indices; byte address is four times the index
`ifndef MLIC_CFG_SVH
`define MLIC_CFG_SVH

`define MLIC_IDX_STATUS      2'h0
`define MLIC_IDX_LASTVEC     2'h1
`define MLIC_IDX_SETUP       2'h2
`define MLIC_IDX_CCPKEY      2'h3
`define MLIC_CCP_SIGNATURE   8'hD8
`define MLIC_CCP_WINDOW      3'h4
`define MLIC_BIT_ROTATE      7
`define MLIC_BIT_VSEL        6
`define MLIC_BIT_HIGH        2
`define MLIC_BIT_MED         1
`define MLIC_BIT_LOW         0
`define MLIC_BIT_NMI_EX      7
`define MLIC_SETUP_RESET     8'h00
`define MLIC_LASTVEC_RESET   8'h00
`define MLIC_RESET_ADDR      16'h0000
`define MLIC_VEC_OFFSET      16'h0002
`define MLIC_LVL_OFF         2'h0
`define MLIC_LVL_LOW         2'h1
`define MLIC_LVL_MED         2'h2
`define MLIC_LVL_HIGH        2'h3

`endif

// file: verilog/mlic_pkg.sv
// Purpose: types for the multilevel interrupt controller core
// Assumes: nothing beyond the cfg header
// Notes:   carrier structs for core-side handshake
package mlic_pkg;

   typedef enum logic [1:0] {
      MLIC_IDLE = 2'h0,
      MLIC_OFFER = 2'h1,
      MLIC_WAIT = 2'h3
   } mlic_state_t;

   typedef struct packed {
      logic        valid;
      logic        nmi;
      logic [1:0]  level;
      logic [7:0]  vector;
   } mlic_grant_t;

   typedef struct packed {
      logic        nmi_ex;
      logic        high_ex;
      logic        med_ex;
      logic        low_ex;
   } mlic_exec_t;

endpackage

// file: verilog/mlic_core.sv
// Purpose: priority and scheduling core of a three-level interrupt controller
// Assumes: request inputs come from logic on clk_i; the core gives one-cycle
//          ack and return_from_interrupt pulses; source index equals vector number
// Notes:   registers over classic wishbone, one 32-bit word per register
//
// The Wishbone register port was left to the implementer.
`include "mlic_cfg.svh"

module mlic_core
   import mlic_pkg::*;
#(
   parameter int NSRC = 16,
   parameter int NNMI = 2,
   parameter logic [15:0] BOOT_ADDR = 16'h1000
) (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 ce_i,
   // wishbone slave
   input  wire logic                 cyc_i,
   input  wire logic                 stb_i,
   input  wire logic                 we_i,
   input  wire logic [3:0]           adr_i,
   input  wire logic [3:0]           sel_i,
   input  wire logic [31:0]          dat_i,
   output logic      [31:0]          dat_o,
   output logic                      ack_o,
   // request sources
   input  wire logic [NSRC*2-1:0]    req_level_i,
   input  wire logic [NNMI-1:0]      nmi_req_i,
   input  wire logic                 boot_reset_fuse_i,
   // processor core side
   input  wire logic                 core_ack_i,
   input  wire logic                 return_from_interrupt_i,
   output logic                      irq_o,
   output logic      [7:0]           vector_o,
   output logic                      vector_nmi_o,
   output logic      [15:0]          vector_address_o,
   output logic      [15:0]          reset_address_o,
   output logic      [3:0]           executing_o
);

   // ***************************************************
   // registers
   // ***************************************************
   logic [7:0]  setup_reg;
   logic [7:0]  last_low_vector_reg;
   mlic_exec_t  exec_reg;
   logic [2:0]  ccp_cnt_reg;
   logic [NSRC*2-1:0] lvl_reg;
   logic [NNMI-1:0]   nmi_reg;
   logic        fuse_reg;
   // second stage of the fuse synchroniser: the fuse pin is not on clk_i
   logic        fuse_sync_reg;
   logic        ack_reg;
   logic [31:0] dat_reg;
   mlic_grant_t grant_reg;
   logic [15:0] rst_addr_reg;

   // gated level enables: registered copy lags the setup register by one cycle
   logic [2:0]  lvl_en_reg;

   // ***************************************************
   // arbitration
   // ***************************************************
   // first set bit at or after start, scanning circularly
   function automatic logic [8:0] pick(input logic [NSRC-1:0] m, input logic [7:0] start);
      logic [8:0] r;
      int         k;
      r = 9'h000;
      for (int i = NSRC - 1; i >= 0; i--) begin
         k = (int'(start) + i) % NSRC;
         if (m[k]) begin
            r = {1'b1, 8'(k)};
         end
      end
      return r;
   endfunction

   logic [NSRC-1:0] pend_hi;
   logic [NSRC-1:0] pend_med;
   logic [NSRC-1:0] pend_lo;
   always_comb begin
      for (int i = 0; i < NSRC; i++) begin
         pend_hi[i]  = lvl_reg[2*i +: 2] == `MLIC_LVL_HIGH;
         pend_med[i] = lvl_reg[2*i +: 2] == `MLIC_LVL_MED;
         pend_lo[i]  = lvl_reg[2*i +: 2] == `MLIC_LVL_LOW;
      end
   end

   wire        rot_on = setup_reg[`MLIC_BIT_ROTATE];
   // rotation start is one past the last acknowledged low vector
   wire [7:0]  lo_start = rot_on ? 8'((int'(last_low_vector_reg) + 1) % NSRC) : 8'h00;
   // fixed scan from zero for nmi, high, medium
   wire [8:0]  win_nmi = pick(NSRC'(nmi_reg), 8'h00);
   wire [8:0]  win_hi  = pick(pend_hi & {NSRC{lvl_en_reg[2]}}, 8'h00);
   wire [8:0]  win_med = pick(pend_med & {NSRC{lvl_en_reg[1]}}, 8'h00);
   wire [8:0]  win_lo  = pick(pend_lo & {NSRC{lvl_en_reg[0]}}, lo_start);

   // only a level above the highest executing one may preempt
   wire        ok_nmi = win_nmi[8] && !exec_reg.nmi_ex;
   wire        ok_hi  = win_hi[8] && !exec_reg.nmi_ex && !exec_reg.high_ex;
   wire        ok_med = win_med[8] && !exec_reg.nmi_ex && !exec_reg.high_ex
                        && !exec_reg.med_ex;
   wire        ok_lo  = win_lo[8] && !(|exec_reg);

   // level first, then priority inside the level
   mlic_grant_t cand;
   always_comb begin
      cand = '0;
      if (ok_nmi) begin
         cand = '{valid: 1'b1, nmi: 1'b1, level: `MLIC_LVL_HIGH, vector: win_nmi[7:0]};
      end else if (ok_hi) begin
         cand = '{valid: 1'b1, nmi: 1'b0, level: `MLIC_LVL_HIGH, vector: win_hi[7:0]};
      end else if (ok_med) begin
         cand = '{valid: 1'b1, nmi: 1'b0, level: `MLIC_LVL_MED, vector: win_med[7:0]};
      end else if (ok_lo) begin
         cand = '{valid: 1'b1, nmi: 1'b0, level: `MLIC_LVL_LOW, vector: win_lo[7:0]};
      end
   end

   // ***************************************************
   // vector placement
   // ***************************************************
   // vector base from vector-select bit
   wire [15:0] vec_base = setup_reg[`MLIC_BIT_VSEL] ? BOOT_ADDR + `MLIC_VEC_OFFSET
                                                    : `MLIC_VEC_OFFSET;
   wire [15:0] vec_addr_next = vec_base + {7'h00, cand.nmi, cand.vector};

   // ***************************************************
   // bus decode
   // ***************************************************
   wire        bus_req  = cyc_i && stb_i && !ack_reg;
   wire        bus_wr   = bus_req && we_i && sel_i[0];
   wire [1:0]  idx      = adr_i[3:2];
   wire        mapped   = adr_i[1:0] == 2'h0;
   wire        wr_setup = bus_wr && mapped && idx == `MLIC_IDX_SETUP;
   wire        wr_last  = bus_wr && mapped && idx == `MLIC_IDX_LASTVEC;
   wire        wr_key   = bus_wr && mapped && idx == `MLIC_IDX_CCPKEY;
   wire        unlocked = ccp_cnt_reg != 3'h0;

   logic [7:0] rd_byte;
   always_comb begin
      case (idx)
         `MLIC_IDX_STATUS:  rd_byte = {exec_reg.nmi_ex, 4'h0, exec_reg.high_ex,
                                       exec_reg.med_ex, exec_reg.low_ex};
         `MLIC_IDX_LASTVEC: rd_byte = last_low_vector_reg;
         `MLIC_IDX_SETUP:   rd_byte = setup_reg;
         `MLIC_IDX_CCPKEY:  rd_byte = {5'h00, ccp_cnt_reg};
         default:           rd_byte = 8'h00;
      endcase
   end
   wire [31:0] dat_next = (mapped && !we_i) ? {24'h000000, rd_byte} : 32'h00000000;

   // vector-select changes only while unlocked; reserved bits read zero
   wire [7:0]  setup_next = {dat_i[7], unlocked ? dat_i[6] : setup_reg[6],
                             3'h0, dat_i[2:0]};
   wire        take = grant_reg.valid && core_ack_i;

   // set on acknowledge; return clears highest active flag only
   mlic_exec_t exec_next;
   always_comb begin
      exec_next = exec_reg;
      if (return_from_interrupt_i) begin
         if (exec_reg.nmi_ex) begin
            exec_next.nmi_ex = 1'b0;
         end else if (exec_reg.high_ex) begin
            exec_next.high_ex = 1'b0;
         end else if (exec_reg.med_ex) begin
            exec_next.med_ex = 1'b0;
         end else begin
            exec_next.low_ex = 1'b0;
         end
      end
      // an acknowledge in the same cycle as a return wins for its own flag
      if (take) begin
         if (grant_reg.nmi) begin
            exec_next.nmi_ex = 1'b1;
         end else begin
            case (grant_reg.level)
               `MLIC_LVL_HIGH: exec_next.high_ex = 1'b1;
               `MLIC_LVL_MED:  exec_next.med_ex = 1'b1;
               `MLIC_LVL_LOW:  exec_next.low_ex = 1'b1;
               default:        exec_next.low_ex = exec_next.low_ex;
            endcase
         end
      end
   end

   // ***************************************************
   // sequential state
   // ***************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         setup_reg <= `MLIC_SETUP_RESET;
         last_low_vector_reg <= `MLIC_LASTVEC_RESET;
         exec_reg <= '0;
         ccp_cnt_reg <= 3'h0;
         lvl_reg <= '0;
         nmi_reg <= '0;
         fuse_reg <= 1'b1;
         fuse_sync_reg <= 1'b1;
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
         grant_reg <= '0;
         lvl_en_reg <= 3'h0;
         rst_addr_reg <= `MLIC_RESET_ADDR;
      end else if (ce_i) begin
         lvl_reg <= req_level_i;
         nmi_reg <= nmi_req_i;
         fuse_reg <= boot_reset_fuse_i;
         fuse_sync_reg <= fuse_reg;
         rst_addr_reg <= fuse_sync_reg ? `MLIC_RESET_ADDR : BOOT_ADDR;
         ack_reg <= bus_req;
         dat_reg <= bus_req ? dat_next : dat_reg;
         // enables act two cycles after the setup write
         lvl_en_reg <= setup_reg[2:0];
         if (wr_setup) begin
            setup_reg <= setup_next;
         end
         if (wr_key && dat_i[7:0] == `MLIC_CCP_SIGNATURE) begin
            ccp_cnt_reg <= `MLIC_CCP_WINDOW;
         end else if (unlocked) begin
            ccp_cnt_reg <= ccp_cnt_reg - 3'h1;
         end
         // capture acknowledged low vector only while rotation is on; a bus write loads it in either mode unless a capture falls in the same cycle
         if (take && !grant_reg.nmi && grant_reg.level == `MLIC_LVL_LOW && rot_on) begin
            last_low_vector_reg <= grant_reg.vector;
         end else if (wr_last) begin
            last_low_vector_reg <= dat_i[7:0];
         end
         exec_reg <= exec_next;
         // offer is re-evaluated every cycle until the core takes it
         grant_reg <= take ? '0 : cand;
      end
   end

   assign ack_o            = ack_reg;
   assign dat_o            = dat_reg;
   assign irq_o            = grant_reg.valid;
   assign vector_o         = grant_reg.vector;
   assign vector_nmi_o     = grant_reg.nmi;
   assign reset_address_o  = rst_addr_reg;
   assign executing_o      = exec_reg;

   logic [15:0] vaddr_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vaddr_reg <= 16'h0000;
      end else if (ce_i) begin
         vaddr_reg <= take ? vaddr_reg : vec_addr_next;
      end
   end
   assign vector_address_o = vaddr_reg;

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // sources numbered below the offered vector; a fixed winner has none pending there
   wire [NSRC-1:0] below_cand = (NSRC'(1) << cand.vector) - NSRC'(1);

   chk_nmi_blocks: assert property (exec_reg.nmi_ex |-> !cand.valid)
      else $error("grant offered during nonmask handler");
   chk_lvl_order: assert property (cand.valid && win_hi[8] && ok_hi
         |-> cand.level == `MLIC_LVL_HIGH)
      else $error("high request lost to lower level");
   chk_fixed_hi: assert property (cand.valid && !cand.nmi && cand.level == `MLIC_LVL_HIGH
         |-> (pend_hi & below_cand) == '0)
      else $error("high winner not smallest vector");
   chk_fixed_med: assert property (cand.valid && !cand.nmi && cand.level == `MLIC_LVL_MED
         |-> (pend_med & below_cand) == '0)
      else $error("medium winner not smallest vector");
   chk_fixed_nmi: assert property (cand.valid && cand.nmi
         |-> (NSRC'(nmi_reg) & below_cand) == '0)
      else $error("nonmask winner not smallest vector");
   chk_fixed_lo: assert property (cand.valid && !cand.nmi && cand.level == `MLIC_LVL_LOW
         && !rot_on |-> (pend_lo & below_cand) == '0)
      else $error("low winner not smallest with rotation off");
   chk_rot_lowest: assert property (cand.valid && !cand.nmi && cand.level == `MLIC_LVL_LOW
         && rot_on && cand.vector == last_low_vector_reg
         |-> (pend_lo & ~(NSRC'(1) << cand.vector)) == '0)
      else $error("last low vector won over another low request");
   chk_enable_lag: assert property (ce_i && wr_setup && !dat_i[0] |=> ce_i |=> !lvl_en_reg[0])
      else $error("low enable did not lag one cycle");
   chk_lo_gate: assert property (!lvl_en_reg[0]
         |-> !(cand.valid && cand.level == `MLIC_LVL_LOW && !cand.nmi))
      else $error("low request taken while disabled");
   chk_med_gate: assert property (!lvl_en_reg[1]
         |-> !(cand.valid && cand.level == `MLIC_LVL_MED && !cand.nmi))
      else $error("medium request taken while disabled");
   chk_hi_gate: assert property (!lvl_en_reg[2]
         |-> !(cand.valid && cand.level == `MLIC_LVL_HIGH && !cand.nmi))
      else $error("high request taken while disabled");
   chk_preempt_lvl: assert property (cand.valid && !cand.nmi && exec_reg.med_ex
         |-> cand.level == `MLIC_LVL_HIGH)
      else $error("offer not above running medium handler");
   chk_rot_capture: assert property (ce_i && take && grant_reg.level == `MLIC_LVL_LOW
         && !grant_reg.nmi && rot_on |=> last_low_vector_reg == $past(grant_reg.vector))
      else $error("last vector not captured");
   chk_last_write: assert property (ce_i && wr_last && !(take && rot_on)
         |=> last_low_vector_reg == $past(dat_i[7:0]))
      else $error("last vector write lost");
   chk_keep_last: assert property (ce_i && !rot_on && !wr_last |=> $stable(last_low_vector_reg))
      else $error("last vector changed with rotation off");
   chk_vsel_lock: assert property (ce_i && wr_setup && !unlocked
         |=> setup_reg[6] == $past(setup_reg[6]))
      else $error("vector select changed while locked");
   chk_vec_base: assert property (ce_i && !take && !setup_reg[`MLIC_BIT_VSEL]
         |=> vaddr_reg == `MLIC_VEC_OFFSET + {7'h00, $past(cand.nmi), $past(cand.vector)})
      else $error("application vector address wrong");
   chk_reset_addr: assert property (ce_i && fuse_sync_reg
         |=> rst_addr_reg == `MLIC_RESET_ADDR)
      else $error("reset address wrong with fuse set");
   chk_return_from_interrupt_one: assert property (ce_i && return_from_interrupt_i && !take
         && exec_reg.nmi_ex |=> exec_reg.high_ex == $past(exec_reg.high_ex))
      else $error("return cleared more than one flag");
   chk_nmi_flag: assert property (ce_i && take && grant_reg.nmi |=> exec_reg.nmi_ex)
      else $error("nonmask executing flag not set");
   chk_nmi_hold: assert property (ce_i && exec_reg.nmi_ex && !return_from_interrupt_i
         |=> exec_reg.nmi_ex)
      else $error("nonmask flag dropped without return");
   chk_hi_flag: assert property (ce_i && take && !grant_reg.nmi
         && grant_reg.level == `MLIC_LVL_HIGH |=> exec_reg.high_ex)
      else $error("high executing flag not set");
   chk_hi_hold: assert property (ce_i && exec_reg.high_ex && exec_reg.nmi_ex
         |=> exec_reg.high_ex)
      else $error("high flag dropped under nonmask handler");
   chk_med_flag: assert property (ce_i && take && !grant_reg.nmi
         && grant_reg.level == `MLIC_LVL_MED |=> exec_reg.med_ex)
      else $error("medium executing flag not set");
   chk_med_hold: assert property (ce_i && exec_reg.med_ex && exec_reg.high_ex
         |=> exec_reg.med_ex)
      else $error("medium flag dropped while preempted");
   chk_low_flag: assert property (ce_i && take && !grant_reg.nmi
         && grant_reg.level == `MLIC_LVL_LOW |=> exec_reg.low_ex)
      else $error("low executing flag not set");
   chk_low_hold: assert property (ce_i && exec_reg.low_ex && exec_reg.med_ex
         |=> exec_reg.low_ex)
      else $error("low flag dropped while preempted");
   chk_ack_pulse: assert property (ce_i && ack_reg |=> !ack_reg)
      else $error("bus acknowledge longer than one cycle");

   cov_nmi_take: cover property (take && grant_reg.nmi);
   cov_preempt: cover property (take && grant_reg.level == `MLIC_LVL_HIGH && exec_reg.low_ex);
   cov_rotate: cover property (take && rot_on && grant_reg.level == `MLIC_LVL_LOW);
   cov_boot_base: cover property (take && setup_reg[`MLIC_BIT_VSEL]);

endmodule

// file: test/mlic_core_model.sv
// Purpose: processor core stand-in that takes offered vectors and returns
// Assumes: irq_i is registered on clk_i by the controller
// Notes:   wait_i sets how many offered cycles pass before a take
module mlic_core_model (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // controller side
   input  wire logic       irq_i,
   output logic            core_ack_o,
   output logic            return_from_interrupt_o,
   // bench control
   input  wire logic       take_i,
   input  wire logic [3:0] wait_i,
   input  wire logic       return_from_interrupt_req_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       [3:0] cnt_reg;
   logic       [3:0] cnt_next;
   wire  logic       busy = irq_i && take_i;
   // a take only while an offer stands, never in two cycles running
   wire  logic       go   = busy && !core_ack_o && (cnt_reg >= wait_i);

   assign cnt_next = !busy ? 4'h0 : ((cnt_reg == 4'hF) ? cnt_reg : cnt_reg + 4'h1);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg    <= 4'h0;
         core_ack_o <= 1'b0;
         return_from_interrupt_o     <= 1'b0;
      end else begin
         cnt_reg    <= cnt_next;
         core_ack_o <= go;
         return_from_interrupt_o     <= return_from_interrupt_req_i && !return_from_interrupt_o;
      end
   end
endmodule

// file: test/mlic_core_tb_top.sv
// Purpose: self-checking bench for the interrupt priority core
// Assumes: NSRC 16, NNMI 2, core model answers on the core side
// Notes:   one task per scenario, register access over classic wishbone
module mlic_core_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************************
   // harness
   // ****************************************************************
   localparam logic [15:0] BOOT = 16'h1000;
   logic              clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic              cyc = 1'b0, stb = 1'b0, we = 1'b0, fuse = 1'b1;
   logic              take = 1'b0, return_from_interrupt_req = 1'b0, ack, irq, vnmi, core_ack, return_from_interrupt;
   logic       [3:0]  adr = 4'h0, wt = 4'h0, exec;
   logic       [31:0] dat = 32'h0, dat_o, req = 32'h0;
   logic       [1:0]  nmi = 2'h0;
   logic       [7:0]  vec;
   logic       [15:0] vaddr, raddr;
   int                bad_count = 0, samples_checked = 0;

   mlic_core #(.NSRC(16), .NNMI(2), .BOOT_ADDR(BOOT)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack),
      .req_level_i(req), .nmi_req_i(nmi), .boot_reset_fuse_i(fuse),
      .core_ack_i(core_ack), .return_from_interrupt_i(return_from_interrupt), .irq_o(irq),
      .vector_o(vec), .vector_nmi_o(vnmi), .vector_address_o(vaddr),
      .reset_address_o(raddr), .executing_o(exec));
   mlic_core_model cpu (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq), .core_ack_o(core_ack),
      .return_from_interrupt_o(return_from_interrupt), .take_i(take), .wait_i(wt), .return_from_interrupt_req_i(return_from_interrupt_req));

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic hang;
      bad_count++;
      print_verdict();
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // reads compare the low byte with e, upper bytes must be zero
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                     input logic [7:0] e);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) hang();
      if (!w) chk(dat_o, {24'h0, e});
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic setreq(input int i, input logic [1:0] l);
      req[2*i +: 2] <= l;
   endtask

   task automatic quiet;
      repeat (8) begin
         @(posedge clk_i);
         chk(irq, 1'h0);
      end
   endtask

   task automatic offer(input logic [7:0] v, input logic n);
      int k;
      k = 0;
      repeat (3) @(posedge clk_i);
      while (irq !== 1'b1 && k < 50) begin
         @(posedge clk_i);
         k++;
      end
      if (irq !== 1'b1) hang();
      chk(vec, v);
      chk(vnmi, n);
   endtask

   task automatic take_it(input logic [3:0] e);
      int k;
      k = 0;
      take <= 1'b1;
      do begin
         @(posedge clk_i);
         k++;
      end while (core_ack !== 1'b1 && k < 50);
      take <= 1'b0;
      if (core_ack !== 1'b1) hang();
      repeat (2) @(posedge clk_i);
      chk(exec, e);
   endtask

   task automatic ret(input logic [3:0] e);
      @(posedge clk_i);
      return_from_interrupt_req <= 1'b1;
      @(posedge clk_i);
      return_from_interrupt_req <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(exec, e);
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset;
      wb(1'h0, 4'h0, 8'h00, 8'h00);
      wb(1'h0, 4'h4, 8'h00, 8'h00);
      wb(1'h0, 4'h8, 8'h00, 8'h00);
      wb(1'h1, 4'h0, 8'hFF, 8'h00);
      wb(1'h0, 4'h0, 8'h00, 8'h00);
      wb(1'h0, 4'h1, 8'h00, 8'h00);
      chk(raddr, 16'h0000);
      fuse <= 1'b0;
      // two synchroniser stages, then the registered address
      repeat (4) @(posedge clk_i);
      chk(raddr, BOOT);
      $display("reset test done");
   endtask

   task automatic t_low;
      setreq(3, 2'h1);
      setreq(5, 2'h1);
      setreq(7, 2'h2);
      quiet();
      wb(1'h1, 4'h8, 8'h01, 8'h00);
      offer(8'h03, 1'h0);
      wt <= 4'h5;
      take_it(4'h1);
      wt <= 4'h0;
      setreq(3, 2'h0);
      ret(4'h0);
      offer(8'h05, 1'h0);
      req <= 32'h0;
      $display("low level test done");
   endtask

   task automatic t_level;
      wb(1'h1, 4'h8, 8'h07, 8'h00);
      setreq(1, 2'h1);
      setreq(9, 2'h3);
      offer(8'h09, 1'h0);
      take_it(4'h4);
      setreq(9, 2'h0);
      setreq(6, 2'h2);
      quiet();
      ret(4'h0);
      offer(8'h06, 1'h0);
      take_it(4'h2);
      setreq(6, 2'h0);
      setreq(9, 2'h3);
      offer(8'h09, 1'h0);
      take_it(4'h6);
      setreq(9, 2'h0);
      ret(4'h2);
      quiet();
      ret(4'h0);
      offer(8'h01, 1'h0);
      take_it(4'h1);
      req <= 32'h0;
      ret(4'h0);
      $display("level test done");
   endtask

   task automatic t_rotate;
      wb(1'h1, 4'h4, 8'h00, 8'h00);
      wb(1'h1, 4'h8, 8'h81, 8'h00);
      setreq(2, 2'h1);
      setreq(4, 2'h1);
      offer(8'h02, 1'h0);
      take_it(4'h1);
      wb(1'h0, 4'h4, 8'h00, 8'h02);
      ret(4'h0);
      offer(8'h04, 1'h0);
      take_it(4'h1);
      ret(4'h0);
      offer(8'h02, 1'h0);
      wb(1'h1, 4'h4, 8'h03, 8'h00);
      offer(8'h04, 1'h0);
      wb(1'h1, 4'h8, 8'h01, 8'h00);
      offer(8'h02, 1'h0);
      wb(1'h0, 4'h4, 8'h00, 8'h03);
      req <= 32'h0;
      $display("rotation test done");
   endtask

   task automatic t_nmi;
      wb(1'h1, 4'h8, 8'h07, 8'h00);
      nmi <= 2'h3;
      offer(8'h00, 1'h1);
      take_it(4'h8);
      nmi <= 2'h0;
      setreq(9, 2'h3);
      quiet();
      ret(4'h0);
      offer(8'h09, 1'h0);
      take_it(4'h4);
      setreq(9, 2'h0);
      nmi <= 2'h2;
      offer(8'h01, 1'h1);
      take_it(4'hC);
      nmi <= 2'h0;
      ret(4'h4);
      ret(4'h0);
      $display("nonmask test done");
   endtask

   task automatic t_vsel;
      setreq(5, 2'h1);
      offer(8'h05, 1'h0);
      chk(vaddr, 16'h0007);
      wb(1'h1, 4'h8, 8'h47, 8'h00);
      wb(1'h0, 4'h8, 8'h00, 8'h07);
      wb(1'h1, 4'hC, 8'hD8, 8'h00);
      wb(1'h1, 4'h8, 8'h47, 8'h00);
      wb(1'h0, 4'h8, 8'h00, 8'h47);
      repeat (3) @(posedge clk_i);
      chk(vaddr, BOOT + 16'h0007);
      req <= 32'h0;
      $display("vector base test done");
   endtask
   // ****************************************************************
   // main
   // ****************************************************************
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_low();
      t_level();
      t_rotate();
      t_nmi();
      t_vsel();
      print_verdict();
   end
endmodule
